// file: inc/sapc_pkg.sv
/*
 * sapc_pkg: constants and carrier types for the converter control block.
 * Assumes a single 50 MHz clock domain; no imports are used by clients.
 */
package sapc_pkg;
	// ----------------------------------------------------------------
	// widths and codes
	// ----------------------------------------------------------------
	localparam int DATA_W = 14;
	localparam logic [13:0] FLAG_CODE = 14'h3F80;
	localparam logic [13:0] ZERO_WORD = 14'h0000;
	localparam logic [2:0] INIT_CONVS = 3'h4;
	localparam int FOLD_BITS = 6;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CONV_TIME_NS = 273;
	// longest time rounds down
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int RESET_PHASE_NS = 45;
	// least time rounds up
	localparam int RESET_PHASE_CYCLES = (RESET_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERDOWN_THRESHOLD_NS = 7200;
	localparam int POWERDOWN_CYCLES =
		(POWERDOWN_THRESHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_CONVERT = 3'b010,
		ST_NAP = 3'b011,
		ST_RESET = 3'b100,
		ST_POWERDOWN = 3'b101
	} sapc_state_t;

	typedef struct packed {
		logic [13:0] code;
		logic init_pending;
	} sapc_result_t;
endpackage : sapc_pkg

// file: core/sapc_buf.sv
/*
 * sapc_buf: two-entry valid/ready buffer for conversion results.
 * Assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module sapc_buf #(
	parameter int WIDTH = 15
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// fill side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// drain side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	logic [WIDTH-1:0] mem_r [2];
	logic [WIDTH-1:0] mem_nxt [2];
	logic wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// ----------------------------------------------------------------
	// pointer and storage update
	// ----------------------------------------------------------------
	always_comb begin
		push = i_valid && (cnt_r != 2'h2);
		pop = i_ready && (cnt_r != 2'h0);
		mem_nxt = mem_r;
		if (push) begin
			mem_nxt[wp_r] = i_data;
		end
		wp_nxt = push ? ~wp_r : wp_r;
		rp_nxt = pop ? ~rp_r : rp_r;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		mem_r <= mem_nxt;
	end

	// honest full and empty
	assign o_ready = (cnt_r != 2'h2);
	assign o_valid = (cnt_r != 2'h0);
	assign o_data = mem_r[rp_r];
endmodule : sapc_buf
`default_nettype wire

// file: core/sapc_ctrl.sv
/*
 * sapc_ctrl: digital control and parallel read port of a 14-bit SAR
 * converter. Start, busy, abort, nap, powerdown/reset and bus read.
 * Assumes all pins are synchronous to i_clk; the analog core hands a
 * result word through i_sar_code when the internal conversion ends.
 */
`timescale 1ns/100ps
`default_nettype none
module sapc_ctrl #(
	parameter int CONV_CYC = sapc_pkg::CONV_CYCLES,
	parameter int PD_CYC = sapc_pkg::POWERDOWN_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// host strobes
	input wire logic i_convert_strobe_n,
	input wire logic i_chip_select_n,
	input wire logic i_read_n,
	input wire logic i_byte_select,
	input wire logic i_nap_enable_n,
	input wire logic i_powerdown_reset_n,
	// analog core result
	input wire logic [13:0] i_sar_code,
	// status
	output logic o_busy,
	output logic o_nap,
	output logic o_powerdown,
	output logic o_init_pending,
	// parallel data bus, data_line_msb is bit 13
	output logic [13:0] o_data,
	output logic o_data_oe
);
	sapc_pkg::sapc_state_t st_r, st_nxt;
	logic cs_q_r, cv_q_r;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0] init_r, init_nxt;
	logic [13:0] res_r, res_nxt;
	logic busy_nxt, nap_nxt, pd_nxt, oe_nxt;
	logic [13:0] dout_nxt;
	logic cs_fall, cv_rise, cv_fall, conv_done, in_reset;
	logic bv, br, bo_v;
	logic [14:0] bd, bo_d;
	sapc_pkg::sapc_result_t bw;
	logic busy_r, nap_r, pd_r, oe_r, ip_r;
	logic [13:0] dout_r;

	// ----------------------------------------------------------------
	// edge detection of host strobes
	// ----------------------------------------------------------------
	// no reset value: tracking the pins through reset avoids a false edge on release
	always_ff @(posedge i_clk) begin
		cs_q_r <= i_chip_select_n;
		cv_q_r <= i_convert_strobe_n;
	end

	assign cs_fall = cs_q_r && !i_chip_select_n;
	assign cv_rise = !cv_q_r && i_convert_strobe_n;
	assign cv_fall = cv_q_r && !i_convert_strobe_n;
	assign in_reset = !i_powerdown_reset_n;
	assign conv_done = (st_r == sapc_pkg::ST_CONVERT) && (cnt_r == 16'(CONV_CYC - 1));

	// ----------------------------------------------------------------
	// main sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		init_nxt = init_r;
		res_nxt = res_r;
		bv = 1'b0;
		if (in_reset) begin
			// reset phase first; long hold powers the core down
			res_nxt = sapc_pkg::FLAG_CODE;
			init_nxt = sapc_pkg::INIT_CONVS;
			if (st_r == sapc_pkg::ST_RESET || st_r == sapc_pkg::ST_POWERDOWN) begin
				cnt_nxt = (cnt_r == 16'(PD_CYC)) ? cnt_r : cnt_r + 16'h0001;
				if (cnt_r >= 16'(PD_CYC - 1)) begin
					st_nxt = sapc_pkg::ST_POWERDOWN;
				end
			end else begin
				st_nxt = sapc_pkg::ST_RESET;
				cnt_nxt = 16'h0001;
			end
		end else begin
			unique case (st_r)
				sapc_pkg::ST_RESET, sapc_pkg::ST_POWERDOWN: begin
					// back to normal as soon as the pin rises
					st_nxt = sapc_pkg::ST_IDLE;
					cnt_nxt = 16'h0000;
				end
				sapc_pkg::ST_IDLE, sapc_pkg::ST_NAP: begin
					if (!i_nap_enable_n && st_r == sapc_pkg::ST_IDLE) begin
						st_nxt = sapc_pkg::ST_NAP;
					end else if (i_nap_enable_n && st_r == sapc_pkg::ST_NAP) begin
						st_nxt = sapc_pkg::ST_IDLE;
					end
					if ((cv_rise && !i_chip_select_n) || (cs_fall && i_convert_strobe_n)) begin
						st_nxt = sapc_pkg::ST_SAMPLE;
					end else if ((cv_fall && !i_chip_select_n)
							|| (cs_fall && !i_convert_strobe_n)) begin
						st_nxt = sapc_pkg::ST_CONVERT;
						cnt_nxt = 16'h0000;
					end
				end
				sapc_pkg::ST_SAMPLE: begin
					if ((cv_fall && !i_chip_select_n) || (cs_fall && !i_convert_strobe_n)) begin
						st_nxt = sapc_pkg::ST_CONVERT;
						cnt_nxt = 16'h0000;
					end
				end
				sapc_pkg::ST_CONVERT: begin
					cnt_nxt = cnt_r + 16'h0001;
					if (cs_fall && i_convert_strobe_n) begin
						// abort: flag code replaces the result
						st_nxt = sapc_pkg::ST_IDLE;
						res_nxt = sapc_pkg::FLAG_CODE;
					end else if (conv_done) begin
						res_nxt = i_sar_code;
						bv = 1'b1;
						init_nxt = (init_r != 3'h0) ? init_r - 3'h1 : 3'h0;
						if (!i_chip_select_n && i_convert_strobe_n) begin
							st_nxt = sapc_pkg::ST_SAMPLE;
						end else if (!i_nap_enable_n) begin
							st_nxt = sapc_pkg::ST_NAP;
						end else begin
							st_nxt = sapc_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					st_nxt = sapc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= sapc_pkg::ST_IDLE;
			cnt_r <= 16'h0000;
			init_r <= sapc_pkg::INIT_CONVS;
			res_r <= sapc_pkg::ZERO_WORD;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			init_r <= init_nxt;
			res_r <= res_nxt;
		end
	end

	// ----------------------------------------------------------------
	// result buffer: a stalled read port holds two finished words; further words are dropped while it is full
	// ----------------------------------------------------------------
	assign bw = '{code: i_sar_code, init_pending: (init_r != 3'h0)};
	assign bd = bw;
	// drain only while nobody is reading, so the init_pending flag of the head word holds
	assign br = i_read_n || i_chip_select_n;

	sapc_buf #(
		.WIDTH(15)
	) u_buf (
		.i_clk(i_clk),
		.i_rst(i_rst || in_reset),
		.i_valid(bv),
		.i_data(bd),
		.o_ready(),
		.o_valid(bo_v),
		.o_data(bo_d),
		.i_ready(br)
	);

	// ----------------------------------------------------------------
	// output registers and bus drive
	// ----------------------------------------------------------------
	always_comb begin
		busy_nxt = (st_nxt == sapc_pkg::ST_CONVERT);
		nap_nxt = (st_nxt == sapc_pkg::ST_NAP);
		pd_nxt = (st_nxt == sapc_pkg::ST_POWERDOWN);
		oe_nxt = !i_chip_select_n && !i_read_n;
		if (i_byte_select) begin
			dout_nxt = {res_nxt[sapc_pkg::FOLD_BITS-1:0], 8'h00};
		end else begin
			dout_nxt = res_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			busy_r <= 1'b0;
			nap_r <= 1'b0;
			pd_r <= 1'b0;
			oe_r <= 1'b0;
			ip_r <= 1'b1;
			dout_r <= sapc_pkg::ZERO_WORD;
		end else begin
			busy_r <= busy_nxt;
			nap_r <= nap_nxt;
			pd_r <= pd_nxt;
			oe_r <= oe_nxt;
			ip_r <= bo_v ? bo_d[0] : (init_nxt != 3'h0);
			dout_r <= dout_nxt;
		end
	end

	assign o_busy = busy_r;
	assign o_nap = nap_r;
	assign o_powerdown = pd_r;
	assign o_init_pending = ip_r;
	assign o_data = dout_r;
	assign o_data_oe = oe_r;
endmodule : sapc_ctrl
`default_nettype wire

// file: test/sapc_props.sv
/* sapc_props: port checker for sapc_ctrl.
   assumes one clock domain with sync reset i_rst. */
`timescale 1ns/100ps
`default_nettype none
module sapc_props #(
	parameter int CONV_CYC = 13
) (
	// watched ports
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_convert_strobe_n,
	input wire logic i_chip_select_n,
	input wire logic i_read_n,
	input wire logic i_byte_select,
	input wire logic i_powerdown_reset_n,
	input wire logic o_busy,
	input wire logic o_nap,
	input wire logic [13:0] o_data,
	input wire logic o_data_oe
);
	logic [7:0] bcnt_r;
	logic [7:0] bcnt_nxt;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// busy run length, so a stuck busy is caught
	always_comb begin
		bcnt_nxt = o_busy ? bcnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge i_clk) begin
		bcnt_r <= i_rst ? 8'h00 : bcnt_nxt;
	end
	// start edges while idle
	sequence s_cv;
		$fell(i_convert_strobe_n) && !i_chip_select_n && !o_busy && i_powerdown_reset_n;
	endsequence
	sequence s_cs;
		$fell(i_chip_select_n) && !i_convert_strobe_n && !o_busy && i_powerdown_reset_n;
	endsequence
	busy_hold_a: assert property (s_cv |=> o_busy [*8])
		else $error("busy short after strobe start");
	cs_start_a: assert property (s_cs |=> o_busy)
		else $error("no busy after select start");
	conv_bound_a: assert property (o_busy |-> bcnt_r < CONV_CYC)
		else $error("conversion too long");
	abort_a: assert property ($fell(i_chip_select_n) && i_convert_strobe_n && o_busy |=> !o_busy)
		else $error("abort ignored");
	bus_on_a: assert property (!i_chip_select_n && !i_read_n |=> o_data_oe)
		else $error("bus not driven");
	bus_off_a: assert property (i_chip_select_n || i_read_n |=> !o_data_oe)
		else $error("bus driven");
	flag_code_a: assert property ($fell(i_powerdown_reset_n) && !i_byte_select |=> o_data == 14'h3F80)
		else $error("no flag code");
	nap_idle_a: assert property (o_nap |-> !o_busy)
		else $error("nap while busy");
endmodule : sapc_props
bind sapc_ctrl sapc_props #(.CONV_CYC(CONV_CYC)) u_props (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_convert_strobe_n(i_convert_strobe_n),
	.i_chip_select_n(i_chip_select_n),
	.i_read_n(i_read_n),
	.i_byte_select(i_byte_select),
	.i_powerdown_reset_n(i_powerdown_reset_n),
	.o_busy(o_busy),
	.o_nap(o_nap),
	.o_data(o_data),
	.o_data_oe(o_data_oe)
);
`default_nettype wire

// file: test/sapc_host.sv
/* sapc_host: host pin model for sapc_ctrl.
   assumes the bench calls its tasks; pins move at the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module sapc_host (
	// clock
	input wire logic i_clk,
	// strobes
	output logic o_convert_strobe_n,
	output logic o_chip_select_n,
	output logic o_read_n,
	output logic o_byte_select,
	// levels
	output logic o_nap_enable_n,
	output logic o_powerdown_reset_n
);
	// idle: selected, strobe high, no read
	initial begin
		{o_chip_select_n, o_convert_strobe_n, o_read_n, o_byte_select} = 4'h6;
		{o_nap_enable_n, o_powerdown_reset_n} = 2'h3;
	end
	// {select, strobe, read, byte} held n edges; returns 1 ns after the last
	task automatic pins(input logic [3:0] v, input int n);
		@(negedge i_clk);
		{o_chip_select_n, o_convert_strobe_n, o_read_n, o_byte_select} = v;
		repeat (n) @(posedge i_clk);
		#1;
	endtask : pins
	// nap and powerdown levels; the caller sets how long
	task automatic lvl(input logic nap_n, input logic pd_n);
		@(negedge i_clk);
		{o_nap_enable_n, o_powerdown_reset_n} = {nap_n, pd_n};
	endtask : lvl
endmodule : sapc_host
`default_nettype wire

// file: test/testbench.sv
/* testbench: directed scenarios for sapc_ctrl.
   assumes sapc_host drives the strobes and a 50 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [13:0] i_sar_code = 14'h0000;
	logic [13:0] last = 14'h0000;
	wire logic i_convert_strobe_n, i_chip_select_n, i_read_n, i_byte_select;
	wire logic i_nap_enable_n, i_powerdown_reset_n;
	wire logic o_busy, o_nap, o_powerdown, o_init_pending, o_data_oe;
	wire logic [13:0] o_data;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	// short powerdown count keeps the run brief
	sapc_ctrl #(.PD_CYC(20)) dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_convert_strobe_n(i_convert_strobe_n),
		.i_chip_select_n(i_chip_select_n),
		.i_read_n(i_read_n),
		.i_byte_select(i_byte_select),
		.i_nap_enable_n(i_nap_enable_n),
		.i_powerdown_reset_n(i_powerdown_reset_n),
		.i_sar_code(i_sar_code),
		.o_busy(o_busy),
		.o_nap(o_nap),
		.o_powerdown(o_powerdown),
		.o_init_pending(o_init_pending),
		.o_data(o_data),
		.o_data_oe(o_data_oe)
	);
	sapc_host host (
		.i_clk(i_clk),
		.o_convert_strobe_n(i_convert_strobe_n),
		.o_chip_select_n(i_chip_select_n),
		.o_read_n(i_read_n),
		.o_byte_select(i_byte_select),
		.o_nap_enable_n(i_nap_enable_n),
		.o_powerdown_reset_n(i_powerdown_reset_n)
	);
	// clock
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	// hang guard, far above the few hundred cycles used
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait on busy
	task automatic wait_busy(input logic v);
		int k;
		k = 0;
		while (o_busy !== v && k < 40) begin
			@(negedge i_clk);
			k++;
		end
		chk(o_busy, v);
	endtask : wait_busy
	task automatic rd(input logic bs, input logic [13:0] exp);
		host.pins({3'b010, bs}, 2);
		chk(o_data_oe, 1'b1);
		chk(o_data, exp);
		host.pins(4'h6, 2);
		chk(o_data_oe, 1'b0);
	endtask : rd
	task automatic conv(input logic [13:0] code);
		@(negedge i_clk);
		i_sar_code = code;
		host.pins(4'h2, 1);
		wait_busy(1'b1);
		rd(1'b0, last);
		wait_busy(1'b0);
		last = code;
		rd(1'b0, code);
		rd(1'b1, {code[5:0], 8'h00});
	endtask : conv
	task automatic t_init();
		logic [13:0] codes [4] = '{14'h2000, 14'h3FFF, 14'h1FFF, 14'h0000};
		chk(o_init_pending, 1'b1);
		for (int i = 0; i < 4; i++) begin
			conv(codes[i]);
			chk(o_init_pending, i < 3);
		end
	endtask : t_init
	task automatic t_start_cs();
		host.pins(4'hE, 2);
		host.pins(4'h6, 2);
		conv(14'h2A55);
		@(negedge i_clk);
		i_sar_code = 14'h15AA;
		host.pins(4'hA, 2);
		host.pins(4'h2, 1);
		wait_busy(1'b1);
		host.pins(4'hA, 1);
		wait_busy(1'b0);
		last = 14'h15AA;
		rd(1'b0, last);
	endtask : t_start_cs
	task automatic t_abort();
		@(negedge i_clk);
		i_sar_code = 14'h1234;
		host.pins(4'h2, 1);
		wait_busy(1'b1);
		host.pins(4'h6, 6);
		host.pins(4'hE, 1);
		host.pins(4'h6, 2);
		chk(o_busy, 1'b0);
		rd(1'b0, 14'h3F80);
	endtask : t_abort
	task automatic t_nap();
		host.lvl(1'b0, 1'b1);
		repeat (3) @(negedge i_clk);
		chk(o_nap, 1'b1);
		host.pins(4'hE, 2);
		host.pins(4'h6, 2);
		chk(o_nap, 1'b0);
		// a conversion ending with the strobe still low drops straight into nap
		@(negedge i_clk);
		i_sar_code = 14'h0ABC;
		host.pins(4'h2, 1);
		wait_busy(1'b1);
		chk(o_nap, 1'b0);
		wait_busy(1'b0);
		chk(o_nap, 1'b1);
		host.lvl(1'b1, 1'b1);
		@(negedge i_clk);
		chk(o_nap, 1'b0);
	endtask : t_nap
	task automatic t_powerdown();
		host.lvl(1'b1, 1'b0);
		repeat (4) @(negedge i_clk);
		chk(o_powerdown, 1'b0);
		rd(1'b0, 14'h3F80);
		repeat (20) @(negedge i_clk);
		chk(o_powerdown, 1'b1);
		host.lvl(1'b1, 1'b1);
		chk(o_init_pending, 1'b1);
	endtask : t_powerdown
	// main sequence
	initial begin
		repeat (16) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		t_init();
		t_start_cs();
		t_abort();
		t_nap();
		t_powerdown();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
